// ===== rtl/rtcc_core.sv
// Operation
// RULE1: Hours bit 6 selects 12-hour mode
// RULE2: 12-hour mode: bit 5 set means PM
// RULE3: 24-hour mode: bit 5 is twenty-hours digit
// RULE4: Weekday counter cycles one to seven
// RULE5: Leap day when year 00 or multiple of 4
// RULE6: Year 99 to 00 toggles century flag
// RULE7: Host should set century flag for 20xx
// RULE8: Alarm register top bit masks its field
// RULE9: All masks set: alarm every second
// RULE10: Only seconds compared: alarm once per minute
// RULE11: Minutes and seconds compared: hourly alarm
// RULE12: Day masked only: daily alarm
// RULE13: No masks: weekly alarm on full match
// RULE14: Every alarm sets timer alarm flag
// RULE15: Search enable plus flag answers search
// RULE16: Time, calendar, alarm held in BCD
// RULE17: Fixed-zero bits always read zero
// RULE18: Seconds tick, BCD carries through calendar
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "rtcc_params.svh"

module rtcc_core #(
  parameter int SEC_CYCLES = `RTCC_SEC_NS / `RTCC_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             search_match
);

  // ==========================================================
  // Functions
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Two-digit year only, so 2100 is wrongly a leap year
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] month_len(input logic [4:0] m,
                                           input logic       leap);
    case (m)
      5'h02:   month_len = leap ? 8'h29 : 8'h28; // RULE5
      5'h04,
      5'h06,
      5'h09,
      5'h11:   month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [7:0]  sec;
  logic [7:0]  min;
  logic [7:0]  hour;
  logic [7:0]  wday;
  logic [7:0]  date;
  logic [7:0]  month;
  logic [7:0]  year;
  logic [7:0]  al_sec;
  logic [7:0]  al_min;
  logic [7:0]  al_hour;
  logic [7:0]  al_wday;
  logic [7:0]  ctrl;
  logic        timer_alarm_flag;
  logic        int_mask;
  logic [31:0] presc;
  logic        tick_d;

  // ==========================================================
  // APB decode
  wire [11:0] idx      = paddr[13:2];
  wire        aligned  = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
  wire        sel_sec  = aligned && (idx == `RTCC_IDX_SEC);
  wire        sel_min  = aligned && (idx == `RTCC_IDX_MIN);
  wire        sel_hour = aligned && (idx == `RTCC_IDX_HOUR);
  wire        sel_wday = aligned && (idx == `RTCC_IDX_WDAY);
  wire        sel_date = aligned && (idx == `RTCC_IDX_DATE);
  wire        sel_mon  = aligned && (idx == `RTCC_IDX_MONTH);
  wire        sel_year = aligned && (idx == `RTCC_IDX_YEAR);
  wire        sel_asec = aligned && (idx == `RTCC_IDX_AL_SEC);
  wire        sel_amin = aligned && (idx == `RTCC_IDX_AL_MIN);
  wire        sel_ahr  = aligned && (idx == `RTCC_IDX_AL_HOUR);
  wire        sel_awd  = aligned && (idx == `RTCC_IDX_AL_WDAY);
  wire        sel_ctrl = aligned && (idx == `RTCC_IDX_CTRL);
  wire        sel_stat = aligned && (idx == `RTCC_IDX_STATUS);
  wire        sel_imsk = aligned && (idx == `RTCC_IDX_INTMASK);
  wire        mapped   = sel_sec | sel_min | sel_hour | sel_wday |
                         sel_date | sel_mon | sel_year | sel_asec |
                         sel_amin | sel_ahr | sel_awd | sel_ctrl |
                         sel_stat | sel_imsk;
  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pwrite && mapped;
  wire [7:0]  wd       = pwdata[7:0];

  wire        wr_sec   = wr_en && sel_sec;
  wire        wr_min   = wr_en && sel_min;
  wire        wr_hour  = wr_en && sel_hour;
  wire        wr_wday  = wr_en && sel_wday;
  wire        wr_date  = wr_en && sel_date;
  wire        wr_mon   = wr_en && sel_mon;
  wire        wr_year  = wr_en && sel_year;
  wire        wr_stat  = wr_en && sel_stat;

  wire [7:0] rd_mux = ({8{sel_sec}}  & sec)     |
                      ({8{sel_min}}  & min)     |
                      ({8{sel_hour}} & hour)    |
                      ({8{sel_wday}} & wday)    |
                      ({8{sel_date}} & date)    |
                      ({8{sel_mon}}  & month)   |
                      ({8{sel_year}} & year)    |
                      ({8{sel_asec}} & al_sec)  |
                      ({8{sel_amin}} & al_min)  |
                      ({8{sel_ahr}}  & al_hour) |
                      ({8{sel_awd}}  & al_wday) |
                      ({8{sel_ctrl}} & ctrl)    |
                      ({8{sel_stat}} & {7'h00, timer_alarm_flag}) |
                      ({8{sel_imsk}} & {7'h00, int_mask});

  // Zero wait states keep the slave simple
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // Second prescaler
  wire osc_run = !ctrl[`RTCC_BIT_OSC_OFF];
  wire tick    = osc_run && (presc == 32'(SEC_CYCLES - 1)); // RULE18
  wire [31:0] next_presc = (wr_sec || !osc_run || tick) ? 32'h0 :
                           presc + 32'h1;

  // ==========================================================
  // Time and calendar carries
  rtcc_pkg::rtcc_hmode_t hmode;
  assign hmode = rtcc_pkg::rtcc_hmode_t'(hour[`RTCC_BIT_HMODE]); // RULE1

  wire [7:0] last_day = month_len(month[4:0], is_leap(year));
  wire       sec_c    = tick && (sec[6:0] == 7'h59); // RULE18
  wire       min_c    = sec_c && (min[6:0] == 7'h59);
  wire       hr12_end = hour[`RTCC_BIT_PM] && (hour[4:0] == 5'h11);
  wire       hr24_end = (hour[5:0] == 6'h23);
  wire       day_c    = min_c && ((hmode == rtcc_pkg::RTCC_HR12) ?
                                  hr12_end : hr24_end);
  wire       mon_c    = day_c && (date == last_day);
  wire       yr_c     = mon_c && (month[4:0] == 5'h12);

  wire [7:0] sec_inc  = bcd_inc(sec);
  wire [7:0] min_inc  = bcd_inc(min);
  wire [7:0] h12_inc  = bcd_inc(hour & 8'h1f);
  wire [7:0] h24_inc  = bcd_inc(hour & 8'h3f);

  // 12-hour: 11 to 12 flips PM, 12 to 01 keeps it
  wire [7:0] hr12_next = (hour[4:0] == 5'h12) ? {hour[7:5], 5'h01} :
                         (hour[4:0] == 5'h11) ?
                         {hour[7:6], ~hour[`RTCC_BIT_PM], 5'h12} :
                         {hour[7:5], h12_inc[4:0]}; // RULE2
  // 24-hour: bit 5 is the twenty-hours digit, 19 to 20 sets it
  wire [7:0] hr24_next = hr24_end ? {hour[7:6], 6'h00} :
                         {hour[7:6], h24_inc[5:0]}; // RULE3
  wire [7:0] hr_adv    = (hmode == rtcc_pkg::RTCC_HR12) ?
                         hr12_next : hr24_next;

  wire [7:0] next_sec  = wr_sec ? (wd & `RTCC_WM_SEC) :
                         !tick ? sec :
                         sec_c ? 8'h00 : sec_inc; // RULE16
  wire [7:0] next_min  = wr_min ? (wd & `RTCC_WM_MIN) :
                         !sec_c ? min :
                         min_c ? 8'h00 : min_inc;
  wire [7:0] next_hour = wr_hour ? (wd & `RTCC_WM_HOUR) :
                         min_c ? hr_adv : hour;
  wire [7:0] next_wday = wr_wday ? (wd & `RTCC_WM_WDAY) :
                         !day_c ? wday :
                         (wday[2:0] == 3'h7) ? 8'h01 :
                         {5'h00, wday[2:0] + 3'h1}; // RULE4
  wire [7:0] next_date = wr_date ? (wd & `RTCC_WM_DATE) :
                         !day_c ? date :
                         mon_c ? 8'h01 : bcd_inc(date); // RULE5
  // Century flag flips only on the 99 to 00 year wrap
  wire [7:0] mon_inc   = bcd_inc({3'b000, month[4:0]});
  wire [7:0] next_mon  = wr_mon ? (wd & `RTCC_WM_MONTH) :
                         !mon_c ? month :
                         yr_c ? {month[`RTCC_BIT_CENTURY_FLAG] ^ (year == 8'h99),
                                 7'h01} : // RULE6
                         {month[7:5], mon_inc[4:0]};
  wire [7:0] next_year = wr_year ? (wd & `RTCC_WM_YEAR) :
                         !yr_c ? year :
                         (year == 8'h99) ? 8'h00 : bcd_inc(year);

  // ==========================================================
  // Alarm compare, one cycle after the tick settles the time
  wire seconds_match_mask = al_sec[`RTCC_BIT_MASK]; // RULE9
  wire minutes_match_mask = al_min[`RTCC_BIT_MASK]; // RULE9
  wire hours_match_mask   = al_hour[`RTCC_BIT_MASK]; // RULE9
  wire weekday_match_mask = al_wday[`RTCC_BIT_MASK]; // RULE9
  wire m_sec  = seconds_match_mask || (sec[6:0] == al_sec[6:0]); // RULE10
  wire m_min  = minutes_match_mask || (min[6:0] == al_min[6:0]); // RULE11
  wire m_hour = hours_match_mask   || (hour[6:0] == al_hour[6:0]); // RULE12
  wire m_wday = weekday_match_mask || (wday[2:0] == al_wday[2:0]); // RULE13
  wire alarm_hit = tick_d && m_sec && m_min && m_hour && m_wday; // RULE8

  // Set wins over a same-cycle write-one-to-clear
  wire next_taf = alarm_hit ||
                  (timer_alarm_flag &&
                   !(wr_stat && wd[`RTCC_BIT_TAF])); // RULE14

  assign search_match = timer_alarm_flag && ctrl[`RTCC_BIT_TAS]; // RULE15
  assign irq          = timer_alarm_flag && int_mask;

  // ==========================================================
  // Storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec              <= `RTCC_RST_ZERO;
      min              <= `RTCC_RST_ZERO;
      hour             <= `RTCC_RST_ZERO;
      wday             <= `RTCC_RST_ONE;
      date             <= `RTCC_RST_ONE;
      month            <= `RTCC_RST_ONE;
      year             <= `RTCC_RST_ZERO;
      al_sec           <= `RTCC_RST_ZERO;
      al_min           <= `RTCC_RST_ZERO;
      al_hour          <= `RTCC_RST_ZERO;
      al_wday          <= `RTCC_RST_ZERO;
      ctrl             <= `RTCC_RST_ZERO;
      timer_alarm_flag <= 1'b0;
      int_mask         <= 1'b0;
      presc            <= 32'h0;
      tick_d           <= 1'b0;
      prdata           <= 32'h0;
    end else begin
      sec              <= next_sec;
      min              <= next_min;
      hour             <= next_hour;
      wday             <= next_wday;
      date             <= next_date;
      month            <= next_mon;
      year             <= next_year;
      timer_alarm_flag <= next_taf;
      presc            <= next_presc;
      tick_d           <= tick;
      if (wr_en && sel_asec) begin
        al_sec <= wd & `RTCC_WM_AL;
      end
      if (wr_en && sel_amin) begin
        al_min <= wd & `RTCC_WM_AL;
      end
      if (wr_en && sel_ahr) begin
        al_hour <= wd & `RTCC_WM_AL;
      end
      if (wr_en && sel_awd) begin
        al_wday <= wd & `RTCC_WM_AL_WDAY; // RULE17
      end
      if (wr_en && sel_ctrl) begin
        ctrl <= wd & `RTCC_WM_CTRL;
      end
      if (wr_en && sel_imsk) begin
        int_mask <= wd[0];
      end
      if (setup) begin
        prdata <= {24'h000000, rd_mux};
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HR12_WRAP: assert property ( // RULE1 RULE2
    min_c && hmode == rtcc_pkg::RTCC_HR12 && hour[4:0] == 5'h11 &&
    !wr_hour |=> hour[4:0] == 5'h12 &&
                 hour[`RTCC_BIT_PM] != $past(hour[`RTCC_BIT_PM]))
    else $error("12-hour wrap wrong");

  AST_HR24_TENS: assert property ( // RULE3
    min_c && hmode == rtcc_pkg::RTCC_HR24 && hour[5:0] == 6'h19 &&
    !wr_hour |=> hour[5:0] == 6'h20)
    else $error("24-hour twenty digit wrong");

  AST_WDAY_WRAP: assert property ( // RULE4
    day_c && wday[2:0] == 3'h7 && !wr_wday |=> wday == 8'h01)
    else $error("weekday did not wrap to one");

  AST_LEAP_DAY: assert property ( // RULE5
    day_c && month[4:0] == 5'h02 && date == 8'h28 && !wr_date &&
    !wr_year && !wr_mon |=> date == (is_leap(year) ? 8'h29 : 8'h01))
    else $error("leap day handling wrong");

  AST_CENTURY_FLAG_TOGGLE: assert property ( // RULE6
    yr_c && year == 8'h99 && !wr_mon && !wr_year |=>
    year == 8'h00 &&
    month[`RTCC_BIT_CENTURY_FLAG] != $past(month[`RTCC_BIT_CENTURY_FLAG]))
    else $error("century flag not toggled");

  // Judged from the raw register bits one cycle back, not the hit wire
  AST_ALARM_MATCH: assert property ( // RULE8 RULE10 RULE11 RULE12 RULE13
    $rose(timer_alarm_flag) |->
    $past(tick_d) &&
    ($past(al_sec[7]) || $past(sec[6:0]) == $past(al_sec[6:0])) &&
    ($past(al_min[7]) || $past(min[6:0]) == $past(al_min[6:0])) &&
    ($past(al_hour[7]) || $past(hour[6:0]) == $past(al_hour[6:0])) &&
    ($past(al_wday[7]) || $past(wday[2:0]) == $past(al_wday[2:0])))
    else $error("alarm without field match");

  AST_EVERY_SEC: assert property ( // RULE9
    tick && seconds_match_mask && minutes_match_mask &&
    hours_match_mask && weekday_match_mask &&
    !wr_en ##1 !wr_en |=> timer_alarm_flag)
    else $error("all-masked alarm missed");

  AST_TAF_SET: assert property ( // RULE14
    alarm_hit |=> timer_alarm_flag)
    else $error("alarm did not set flag");

  AST_SEARCH: assert property ( // RULE15
    $rose(timer_alarm_flag) && ctrl[`RTCC_BIT_TAS] |-> search_match)
    else $error("search not answered");

  AST_BCD_SEC: assert property ( // RULE16 RULE18
    tick && !wr_sec |=> sec[3:0] <= 4'h9 &&
                        (sec == 8'h00 || sec != $past(sec)))
    else $error("seconds not advanced in BCD");

  AST_ZERO_BITS: assert property ( // RULE17
    sec[7] == 1'b0 && min[7] == 1'b0 && hour[7] == 1'b0 &&
    wday[7:3] == 5'h00 && date[7:6] == 2'h0 && month[6:5] == 2'h0 &&
    al_wday[6:3] == 4'h0)
    else $error("fixed-zero bit set");

  AST_MINUTE_MISS: assert property ( // RULE10
    tick_d && !al_sec[7] && sec[6:0] != al_sec[6:0] &&
    !timer_alarm_flag |=> !timer_alarm_flag)
    else $error("alarm despite seconds mismatch");

  AST_HOURLY_HIT: assert property ( // RULE11
    tick_d && !al_sec[7] && !al_min[7] && al_hour[7] && al_wday[7] &&
    sec == al_sec && min == al_min |=> timer_alarm_flag)
    else $error("hourly alarm missed");

  AST_DAILY_HIT: assert property ( // RULE12
    tick_d && !al_sec[7] && !al_min[7] && !al_hour[7] && al_wday[7] &&
    sec == al_sec && min == al_min && hour == al_hour |=> timer_alarm_flag)
    else $error("daily alarm missed");

  AST_WEEKLY_HIT: assert property ( // RULE13
    tick_d && !al_sec[7] && !al_min[7] && !al_hour[7] && !al_wday[7] &&
    sec == al_sec && min == al_min && hour == al_hour &&
    wday == al_wday |=> timer_alarm_flag)
    else $error("weekly alarm missed");

  // Sticky flag: only a written one may clear it
  AST_TAF_CLEAR: assert property ( // RULE14
    wr_stat && wd[`RTCC_BIT_TAF] && !alarm_hit |=> !timer_alarm_flag)
    else $error("flag not cleared by write");

  AST_TAF_HOLD: assert property ( // RULE14
    !alarm_hit && !(wr_stat && wd[`RTCC_BIT_TAF]) |=>
    $stable(timer_alarm_flag))
    else $error("flag changed without cause");

  AST_DATE_ADV: assert property ( // RULE18
    day_c && !mon_c && !wr_date |=> date != $past(date) &&
                                    date[3:0] <= 4'h9)
    else $error("date did not advance in BCD");

  COV_WEEKLY: cover property (
    alarm_hit && !seconds_match_mask && !minutes_match_mask &&
    !hours_match_mask && !weekday_match_mask);
  COV_CENTURY: cover property (yr_c && year == 8'h99);
  COV_PM_FLIP: cover property (min_c && hmode == rtcc_pkg::RTCC_HR12);
  COV_IRQ: cover property ($rose(irq));

endmodule

// ===== rtl/rtcc_params.svh
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

// ============================================================
// Register indices; byte address is four times the index
`define RTCC_IDX_SEC      12'h200
`define RTCC_IDX_MIN      12'h201
`define RTCC_IDX_HOUR     12'h202
`define RTCC_IDX_WDAY     12'h203
`define RTCC_IDX_DATE     12'h204
`define RTCC_IDX_MONTH    12'h205
`define RTCC_IDX_YEAR     12'h206
`define RTCC_IDX_AL_SEC   12'h207
`define RTCC_IDX_AL_MIN   12'h208
`define RTCC_IDX_AL_HOUR  12'h209
`define RTCC_IDX_AL_WDAY  12'h20a
`define RTCC_IDX_CTRL     12'h20e
`define RTCC_IDX_STATUS   12'h214
`define RTCC_IDX_INTMASK  12'h220

// ============================================================
// Writable bits; all others read as zero
`define RTCC_WM_SEC       8'h7f
`define RTCC_WM_MIN       8'h7f
`define RTCC_WM_HOUR      8'h7f
`define RTCC_WM_WDAY      8'h07
`define RTCC_WM_DATE      8'h3f
`define RTCC_WM_MONTH     8'h9f
`define RTCC_WM_YEAR      8'hff
`define RTCC_WM_AL        8'hff
`define RTCC_WM_AL_WDAY   8'h87
`define RTCC_WM_CTRL      8'hdf

// ============================================================
// Field positions
`define RTCC_BIT_HMODE    6
`define RTCC_BIT_PM       5
`define RTCC_BIT_CENTURY_FLAG     7
`define RTCC_BIT_MASK     7
`define RTCC_BIT_OSC_OFF  7
`define RTCC_BIT_TAS      0
`define RTCC_BIT_TAF      0

// ============================================================
// Reset values
`define RTCC_RST_ZERO     8'h00
`define RTCC_RST_ONE      8'h01

// ============================================================
// Timing: one oscillator second at a 100 ns clock
`define RTCC_SEC_NS       1000000000
`define RTCC_CLK_NS       100

`endif

// ===== rtl/rtcc_pkg.sv
package rtcc_pkg;
  typedef enum logic [0:0] {
    RTCC_HR24 = 1'b0,
    RTCC_HR12 = 1'b1
  } rtcc_hmode_t;
endpackage

// ===== verif/rtcc_host.sv
`timescale 1ns/1ps
// ============================================================
// APB host standing in for the far-side master
module rtcc_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [15:0] paddr,
  output logic      [31:0] pwdata,
  output logic             done,
  output logic             hung,
  output logic      [32:0] got
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    done = 1'h0;
    hung = 1'h0;
    got = 33'h0;
  end

  // One transfer; holds the request until pready is sampled high, for at most 64 cycles
  task automatic xfer(input logic w, input logic [11:0] idx,
                      input logic [7:0] d);
    int n;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    hung    <= (pready !== 1'h1);
    got     <= {pslverr, prdata};
    done    <= !w;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    done    <= 1'h0;
  endtask
endmodule

// ===== verif/bcd_calendar_clock_with_alarm_tb.sv
`timescale 1ns/1ps
`include "rtcc_params.svh"
module bcd_calendar_clock_with_alarm_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        search_match;
  logic        done;
  logic        hung;
  logic [32:0] got;
  logic [32:0] expq[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed = 32'hb3167499;

  // Short second keeps each rollover run to a few dozen cycles
  rtcc_core #(.SEC_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .search_match(search_match));
  rtcc_host h (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .done(done), .hung(hung),
    .got(got));

  initial pclk = 1'h0;
  always #50 pclk = ~pclk;

  // ============================================================
  // Reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_rd(input logic [32:0] e, input logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected read exp %h got %h", e, s);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask

  // Monitor: each completed read takes the oldest note
  always @(posedge pclk) begin
    if (done === 1'h1)
      chk_rd(expq.pop_front(), got);
    if (hung === 1'h1) begin
      error_cnt++;
      conclude();
    end
  end

  // ============================================================
  // Bus helpers
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    h.xfer(1'h1, i, d);
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    expq.push_back({1'h0, 24'h0, e});
    h.xfer(1'h0, i, 8'h00);
  endtask

  // Rows: hour date month year, then expected hour date month year
  logic [63:0] roll[7] = '{64'h23_31_12_99_00_01_81_00,
    64'h23_28_02_04_00_29_02_04, 64'h23_28_02_00_00_29_02_00,
    64'h23_28_02_01_00_01_03_01, 64'h71_30_04_05_52_01_05_05,
    64'h51_15_86_23_72_15_86_23, 64'h19_10_01_07_20_10_01_07};
  // Alarm rows: masks, sec min hour weekday values, flag expected
  logic [3:0]  amk[9] = '{4'hf, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h1,
                          4'h0, 4'h0};
  logic [31:0] aval[9] = '{32'h30100506, 32'h59100506, 32'h30592303,
    32'h59302303, 32'h59590506, 32'h59592203, 32'h59592306,
    32'h59592305, 32'h59592303};
  logic [8:0]  aexp = 9'b1_0101_0011;
  logic [11:0] ridx[8] = '{`RTCC_IDX_CTRL, `RTCC_IDX_STATUS,
    `RTCC_IDX_HOUR, `RTCC_IDX_WDAY, `RTCC_IDX_DATE, `RTCC_IDX_MONTH,
    `RTCC_IDX_YEAR, `RTCC_IDX_AL_HOUR};
  logic [7:0]  rval[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
                           8'h00, 8'h00};

  // ============================================================
  // Main sequence
  initial begin
    logic [63:0] r;
    logic [7:0]  d;
    presetn = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
      rd(ridx[i], rval[i]);
    wr(`RTCC_IDX_CTRL, 8'h80);
    wr(`RTCC_IDX_SEC, 8'hff);
    rd(`RTCC_IDX_SEC, 8'h7f);
    wr(`RTCC_IDX_MONTH, 8'hff);
    rd(`RTCC_IDX_MONTH, 8'h9f);
    wr(`RTCC_IDX_AL_WDAY, 8'hff);
    rd(`RTCC_IDX_AL_WDAY, 8'h87);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(`RTCC_IDX_AL_MIN, d);
      rd(`RTCC_IDX_AL_MIN, d);
      wr(`RTCC_IDX_WDAY, d);
      rd(`RTCC_IDX_WDAY, d & 8'h07);
    end
    // Unmapped index answers with an error and zero data
    expq.push_back({1'h1, 32'h0});
    h.xfer(1'h0, 12'h20b, 8'h00);
    for (int i = 0; i < 7; i++) begin
      r = roll[i];
      wr(`RTCC_IDX_CTRL, 8'h80);
      wr(`RTCC_IDX_SEC, 8'h59);
      wr(`RTCC_IDX_MIN, 8'h59);
      wr(`RTCC_IDX_HOUR, r[63:56]);
      wr(`RTCC_IDX_WDAY, 8'h07);
      wr(`RTCC_IDX_DATE, r[55:48]);
      wr(`RTCC_IDX_MONTH, r[47:40]);
      wr(`RTCC_IDX_YEAR, r[39:32]);
      wr(`RTCC_IDX_CTRL, 8'h00);
      repeat (10) @(posedge pclk);
      wr(`RTCC_IDX_CTRL, 8'h80);
      rd(`RTCC_IDX_SEC, 8'h00);
      rd(`RTCC_IDX_MIN, 8'h00);
      rd(`RTCC_IDX_HOUR, r[31:24]);
      rd(`RTCC_IDX_WDAY, (r[23:16] == r[55:48]) ? 8'h07 : 8'h01);
      rd(`RTCC_IDX_DATE, r[23:16]);
      rd(`RTCC_IDX_MONTH, r[15:8]);
      rd(`RTCC_IDX_YEAR, r[7:0]);
    end
    for (int i = 0; i < 9; i++) begin
      // Search enable kept on so the search output follows the flag
      wr(`RTCC_IDX_CTRL, 8'h81);
      wr(`RTCC_IDX_SEC, 8'h58);
      wr(`RTCC_IDX_MIN, 8'h59);
      wr(`RTCC_IDX_HOUR, 8'h23);
      wr(`RTCC_IDX_WDAY, 8'h03);
      wr(`RTCC_IDX_AL_SEC, {amk[i][3], aval[i][30:24]});
      wr(`RTCC_IDX_AL_MIN, {amk[i][2], aval[i][22:16]});
      wr(`RTCC_IDX_AL_HOUR, {amk[i][1], aval[i][14:8]});
      wr(`RTCC_IDX_AL_WDAY, {amk[i][0], aval[i][6:0]});
      wr(`RTCC_IDX_INTMASK, {7'h0, i[0]});
      wr(`RTCC_IDX_STATUS, 8'h01);
      wr(`RTCC_IDX_CTRL, 8'h01);
      repeat (18) @(posedge pclk);
      wr(`RTCC_IDX_CTRL, 8'h81);
      rd(`RTCC_IDX_STATUS, {7'h0, aexp[i]});
      chk_pin("irq", aexp[i] & i[0], irq);
      chk_pin("search", aexp[i], search_match);
      wr(`RTCC_IDX_STATUS, 8'h01);
      chk_pin("irq", 1'h0, irq);
    end
    repeat (4) @(posedge pclk);
    conclude();
  end
endmodule
